//--- rtl/tcx_pkg.sv
// Purpose: Shared constants for the 16-bit timer/event counter with capture.
// Assumes: 32-bit AHB-Lite register bus, one system clock at 25 MHz.
// Notes: Offsets are byte addresses of aligned words.
package tcx_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_PRESCALER = 8'h04;
  localparam logic [7:0] OFS_CAPCTL = 8'h08;
  localparam logic [7:0] OFS_COUNT = 8'h0c;
  localparam logic [7:0] OFS_REGA = 8'h10;
  localparam logic [7:0] OFS_REGB = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  // Field positions
  localparam int MODE_ONESHOT_BIT = 0;
  localparam int MODE_OP_LSB = 2;
  localparam int PRE_CLKSEL_LSB = 0;
  localparam int PRE_EDGEA_LSB = 4;
  localparam int PRE_EDGEB_LSB = 6;
  localparam int CAP_A_MODE_BIT = 0;
  localparam int CAP_A_SRC_BIT = 1;
  localparam int CAP_B_MODE_BIT = 2;
  localparam int STAT_WRAP_BIT = 0;
  localparam int STAT_SHOT_BIT = 1;
  // Reset values and count limits
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] PRESCALER_RST = 8'h00;
  localparam logic [2:0] CAPCTL_RST = 3'h0;
  localparam logic [15:0] REG_RST = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  localparam logic [15:0] COUNT_ONE = 16'h0001;
  // Prescaler divide ratios of the system clock
  localparam int DIV_SEL0 = 2;
  localparam int DIV_SEL1 = 4;
  localparam int DIV_SEL2 = 16;
  // Operating modes
  typedef enum logic [1:0] {
    OP_STOP = 2'h0,
    OP_CLR_EDGE = 2'h1,
    OP_FREE = 2'h2,
    OP_CLR_MATCH = 2'h3
  } tcx_op_t;
  // Count clock sources
  typedef enum logic [1:0] {
    CK_DIV0 = 2'h0,
    CK_DIV1 = 2'h1,
    CK_DIV2 = 2'h2,
    CK_EXTA = 2'h3
  } tcx_clksel_t;
  // Edge selects
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_NONE = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
endpackage

//--- rtl/tcx_edge_filter.sv
// Purpose: Edge detector with two-sample noise filter for one input pin.
// Assumes: Pin is synchronous to clk; sampleEn marks sampling instants.
// Notes: Filtered level starts low so a pin high at first start shows a rise.
`timescale 1ns/100ps
module tcx_edge_filter
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Pin and control
  input wire logic pinIn,
  input wire logic sampleEn,
  input wire logic run,
  input wire logic track,
  input wire logic [1:0] edgeSel,
  // Result
  output logic edgePulse
);
  logic sampleFf;
  logic levelFf;
  logic edgeFf;
  logic rise;
  logic fall;

  // Sample register, one per sampling instant
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      sampleFf <= 1'b0;
    else if (sampleEn || track)
      sampleFf <= pinIn;
  end

  assign rise = run && sampleEn && (sampleFf == pinIn) && pinIn && !levelFf;
  assign fall = run && sampleEn && (sampleFf == pinIn) && !pinIn && levelFf;

  // Filtered level; follows the pin silently while stopped after the first start since reset
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      levelFf <= 1'b0;
    else if (track)
      levelFf <= pinIn;
    else if (rise || fall)
      levelFf <= pinIn;
  end

  // Edge pulse by edge select
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      edgeFf <= 1'b0;
    else
      edgeFf <= (rise && (edgeSel == tcx_pkg::EDGE_RISE || edgeSel == tcx_pkg::EDGE_BOTH))
        || (fall && (edgeSel == tcx_pkg::EDGE_FALL || edgeSel == tcx_pkg::EDGE_BOTH));
  end

  assign edgePulse = edgeFf;
endmodule

//--- rtl/tcx_prescaler.sv
// Purpose: Count clock phase generator from the system clock.
// Assumes: Divide ratios are even.
// Notes: riseTick and fallTick are one-cycle pulses half a period apart.
`timescale 1ns/100ps
module tcx_prescaler
#(
  parameter int DIV0 = tcx_pkg::DIV_SEL0,
  parameter int DIV1 = tcx_pkg::DIV_SEL1,
  parameter int DIV2 = tcx_pkg::DIV_SEL2
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic run,
  input wire logic [1:0] clkSel,
  // Phases
  output logic riseTick,
  output logic fallTick
);
  logic [7:0] divCntFf;
  logic [7:0] divLast;

  // Terminal count for the chosen ratio
  always_comb
  begin
    case (clkSel)
      2'h0: divLast = 8'(DIV0 - 1);
      2'h1: divLast = 8'(DIV1 - 1);
      default: divLast = 8'(DIV2 - 1);
    endcase
  end

  // Free divider, held at zero while stopped
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      divCntFf <= 8'h00;
    else if (!run || divCntFf >= divLast)
      divCntFf <= 8'h00;
    else
      divCntFf <= divCntFf + 8'h01;
  end

  assign riseTick = run && (divCntFf == 8'h00);
  assign fallTick = run && (divCntFf == ((divLast >> 1) + 8'h01));
endmodule

//--- rtl/tcx_timer.sv
// Purpose: 16-bit timer/event counter with two capture/compare registers.
// Assumes: AHB-Lite slave, single word transfers, inputs synchronous to clk.
// Notes: Count clock is a pair of phase pulses; zero wait state bus answer.
//
// Local design decisions: register access over AHB-Lite and the register addresses.
`timescale 1ns/100ps
module tcx_timer
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // External inputs
  input wire logic ext_input_a,
  input wire logic ext_input_b,
  // Events
  output logic event_irq_a,
  output logic event_irq_b,
  output logic oneShotOut
);
  // Register state
  logic [7:0] modeFf;
  logic [7:0] prescalerModeFf;
  logic [2:0] capCtlFf;
  logic [15:0] countValueFf;
  logic [15:0] capcompRegAFf;
  logic [15:0] capcompRegBFf;
  logic wrapFlagFf;
  logic wrapHoldFf;
  logic seenRunFf;
  // Bus state
  logic wrPendFf;
  logic [7:0] wrAddrFf;
  logic [31:0] hrdataFf;
  logic hreadyoutFf;
  logic hrespFf;
  // Event state
  logic capAPendFf;
  logic capBPendFf;
  logic irqAPendFf;
  logic irqBPendFf;
  logic clrPendFf;
  logic extFallFf;
  logic irqAFf;
  logic irqBFf;
  logic shotFf;
  // Combinational
  logic run;
  logic extClk;
  logic riseTick;
  logic fallTick;
  logic countTick;
  logic countFall;
  logic edgeA;
  logic edgeB;
  logic trigA;
  logic trigB;
  logic [15:0] nxt_count;
  logic addrPhase;
  logic wrStrobe;
  logic matchA;
  logic matchB;
  logic shotMode;
  tcx_pkg::tcx_op_t opMode;

  // Word decode of a bus offset, shared by read and write paths
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    hit = (addr[7:2] == ofs[7:2]);
  endfunction

  assign opMode = tcx_pkg::tcx_op_t'(modeFf[tcx_pkg::MODE_OP_LSB +: 2]);
  assign run = (opMode != tcx_pkg::OP_STOP);
  assign extClk = (prescalerModeFf[tcx_pkg::PRE_CLKSEL_LSB +: 2] == tcx_pkg::CK_EXTA);

  // Internal count clock phases
  tcx_prescaler u_prescaler
  (
    .clk(clk),
    .rst_n(rst_n),
    .run(run),
    .clkSel(prescalerModeFf[tcx_pkg::PRE_CLKSEL_LSB +: 2]),
    .riseTick(riseTick),
    .fallTick(fallTick)
  );

  // Input a: system clock sampling as count clock, count clock sampling as trigger
  tcx_edge_filter u_filter_a
  (
    .clk(clk),
    .rst_n(rst_n),
    .pinIn(ext_input_a),
    .sampleEn(extClk ? run : riseTick),
    .run(run),
    .track(!run && seenRunFf),
    .edgeSel(prescalerModeFf[tcx_pkg::PRE_EDGEA_LSB +: 2]),
    .edgePulse(edgeA)
  );

  // Input b: always sampled on the prescaler rising phase
  tcx_edge_filter u_filter_b
  (
    .clk(clk),
    .rst_n(rst_n),
    .pinIn(ext_input_b),
    .sampleEn(riseTick),
    .run(run),
    .track(!run && seenRunFf),
    .edgeSel(prescalerModeFf[tcx_pkg::PRE_EDGEB_LSB +: 2]),
    .edgePulse(edgeB)
  );

  // Count clock: input a edges or the prescaler phases
  assign countTick = run && (extClk ? edgeA : riseTick);
  assign countFall = extClk ? extFallFf : fallTick;
  assign trigA = edgeA && !extClk;
  assign trigB = edgeB;

  // Falling phase of the external count clock, one cycle after its edge
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      extFallFf <= 1'b0;
    else
      extFallFf <= extClk && countTick;
  end

  // Remember that counting has started once since reset
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      seenRunFf <= 1'b0;
    else if (run)
      seenRunFf <= 1'b1;
  end

  // Next count value by mode
  assign matchA = (countValueFf == capcompRegAFf);
  assign matchB = (countValueFf == capcompRegBFf);
  always_comb
  begin
    if (opMode == tcx_pkg::OP_CLR_EDGE && clrPendFf)
      nxt_count = 16'h0000;
    else if (opMode == tcx_pkg::OP_CLR_MATCH && matchA)
      nxt_count = 16'h0000;
    else
      nxt_count = countValueFf + 16'h0001;
  end

  // Counter
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      countValueFf <= tcx_pkg::REG_RST;
    else if (!run)
      countValueFf <= tcx_pkg::REG_RST;
    else if (countTick)
      countValueFf <= nxt_count;
  end

  // Clear request from an input a edge, applied on the next count tick
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      clrPendFf <= 1'b0;
    else if (trigA && !(shotMode && shotFf))
      clrPendFf <= 1'b1;
    else if (countTick || !run)
      clrPendFf <= 1'b0;
  end

  // Wrap flag with a hold window until the count reaches 0001
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wrapFlagFf <= 1'b0;
      wrapHoldFf <= 1'b0;
    end
    else
    begin
      if (countTick && countValueFf == tcx_pkg::COUNT_MAX && nxt_count == 16'h0000)
        wrapHoldFf <= 1'b1;
      else if (countValueFf == tcx_pkg::COUNT_ONE || !run)
        wrapHoldFf <= 1'b0;
      if (countTick && countValueFf == tcx_pkg::COUNT_MAX && nxt_count == 16'h0000)
        wrapFlagFf <= 1'b1;
      else if (wrapHoldFf)
        wrapFlagFf <= 1'b1;
      else if (wrStrobe && hit(wrAddrFf, tcx_pkg::OFS_STATUS) && !hwdata[tcx_pkg::STAT_WRAP_BIT])
        wrapFlagFf <= 1'b0;
    end
  end

  // Capture triggers wait for the falling phase
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      capAPendFf <= 1'b0;
      capBPendFf <= 1'b0;
    end
    else
    begin
      if (capCtlFf[tcx_pkg::CAP_A_MODE_BIT]
          && (capCtlFf[tcx_pkg::CAP_A_SRC_BIT] ? trigA : trigB))
        capAPendFf <= 1'b1;
      else if (countFall || !run)
        capAPendFf <= 1'b0;
      if (capCtlFf[tcx_pkg::CAP_B_MODE_BIT] && trigA)
        capBPendFf <= 1'b1;
      else if (countFall || !run)
        capBPendFf <= 1'b0;
    end
  end

  // Capture/compare register a: capture beats a bus write
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      capcompRegAFf <= tcx_pkg::REG_RST;
    else if (capAPendFf && countFall)
      capcompRegAFf <= countValueFf;
    else if (wrStrobe && hit(wrAddrFf, tcx_pkg::OFS_REGA))
      capcompRegAFf <= hwdata[15:0];
  end

  // Capture/compare register b: capture beats a bus write
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      capcompRegBFf <= tcx_pkg::REG_RST;
    else if (capBPendFf && countFall)
      capcompRegBFf <= countValueFf;
    else if (wrStrobe && hit(wrAddrFf, tcx_pkg::OFS_REGB))
      capcompRegBFf <= hwdata[15:0];
  end

  // Capture requests held until the next rising phase
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irqAPendFf <= 1'b0;
      irqBPendFf <= 1'b0;
    end
    else
    begin
      if (capAPendFf && countFall)
        irqAPendFf <= 1'b1;
      else if (countTick || !run)
        irqAPendFf <= 1'b0;
      if (capBPendFf && countFall)
        irqBPendFf <= 1'b1;
      else if (countTick || !run)
        irqBPendFf <= 1'b0;
    end
  end

  // Interrupt pulses: capture on the rising phase, or compare match
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irqAFf <= 1'b0;
      irqBFf <= 1'b0;
    end
    else
    begin
      irqAFf <= countTick && (irqAPendFf
        || (!capCtlFf[tcx_pkg::CAP_A_MODE_BIT] && matchA));
      irqBFf <= countTick && (irqBPendFf
        || (!capCtlFf[tcx_pkg::CAP_B_MODE_BIT] && matchB));
    end
  end

  // One-shot pulse: high from match b to match a, retriggers ignored
  assign shotMode = modeFf[tcx_pkg::MODE_ONESHOT_BIT]
    && (opMode == tcx_pkg::OP_FREE || opMode == tcx_pkg::OP_CLR_EDGE);
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      shotFf <= 1'b0;
    else if (!shotMode)
      shotFf <= 1'b0;
    else if (countTick && matchA)
      shotFf <= 1'b0;
    else if (countTick && matchB)
      shotFf <= 1'b1;
  end

  // Bus address phase and deferred write
  assign addrPhase = hsel && htrans[1] && hready;
  assign wrStrobe = wrPendFf;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wrPendFf <= 1'b0;
      wrAddrFf <= 8'h00;
    end
    else
    begin
      wrPendFf <= addrPhase && hwrite && (hsize == 3'h2);
      if (addrPhase)
        wrAddrFf <= haddr[7:0];
    end
  end

  // Control registers written by software
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      modeFf <= tcx_pkg::MODE_RST;
      prescalerModeFf <= tcx_pkg::PRESCALER_RST;
      capCtlFf <= tcx_pkg::CAPCTL_RST;
    end
    else if (wrStrobe)
    begin
      if (hit(wrAddrFf, tcx_pkg::OFS_MODE))
        modeFf <= hwdata[7:0];
      if (hit(wrAddrFf, tcx_pkg::OFS_PRESCALER))
        prescalerModeFf <= hwdata[7:0];
      if (hit(wrAddrFf, tcx_pkg::OFS_CAPCTL))
        capCtlFf <= hwdata[2:0];
    end
  end

  // Read data captured in the address phase; unmapped reads give zero
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      hrdataFf <= 32'h0000_0000;
    else if (addrPhase && !hwrite)
    begin
      if (hit(haddr[7:0], tcx_pkg::OFS_MODE))
        hrdataFf <= {24'h000000, modeFf};
      else if (hit(haddr[7:0], tcx_pkg::OFS_PRESCALER))
        hrdataFf <= {24'h000000, prescalerModeFf};
      else if (hit(haddr[7:0], tcx_pkg::OFS_CAPCTL))
        hrdataFf <= {29'h0, capCtlFf};
      else if (hit(haddr[7:0], tcx_pkg::OFS_COUNT))
        hrdataFf <= {16'h0000, countValueFf};
      else if (hit(haddr[7:0], tcx_pkg::OFS_REGA))
        hrdataFf <= {16'h0000, capcompRegAFf};
      else if (hit(haddr[7:0], tcx_pkg::OFS_REGB))
        hrdataFf <= {16'h0000, capcompRegBFf};
      else if (hit(haddr[7:0], tcx_pkg::OFS_STATUS))
        hrdataFf <= {30'h0, shotFf, wrapFlagFf};
      else
        hrdataFf <= 32'h0000_0000;
    end
  end

  // Always ready, always OKAY
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hreadyoutFf <= 1'b1;
      hrespFf <= 1'b0;
    end
    else
    begin
      hreadyoutFf <= 1'b1;
      hrespFf <= 1'b0;
    end
  end

  assign hrdata = hrdataFf;
  assign hreadyout = hreadyoutFf;
  assign hresp = hrespFf;
  assign event_irq_a = irqAFf;
  assign event_irq_b = irqBFf;
  assign oneShotOut = shotFf;
endmodule

//--- tb/tcx_timer_checker.sv
// Purpose: Port level checks on the timer block.
// Assumes: One AHB-Lite master doing word transfers.
// Notes: Operating mode is tracked from the bus writes seen.
`timescale 1ns/100ps
module tcx_timer_checker
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // Events
  input wire logic event_irq_a,
  input wire logic event_irq_b
);
  logic rdPh_ff;
  logic wrPh_ff;
  logic [7:0] adrPh_ff;
  logic [1:0] opSh_ff;
  logic [4:0] stopCnt_ff;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Data phase tracking
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdPh_ff <= 1'b0;
      wrPh_ff <= 1'b0;
      adrPh_ff <= 8'h00;
    end
    else if (hready)
    begin
      rdPh_ff <= hsel & htrans[1] & ~hwrite;
      wrPh_ff <= hsel & htrans[1] & hwrite;
      adrPh_ff <= haddr[7:0];
    end
  end
  // Mode shadow from writes
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      opSh_ff <= 2'h0;
    else if (hready && wrPh_ff && adrPh_ff == tcx_pkg::OFS_MODE)
      opSh_ff <= hwdata[3:2];
  end
  // Cycles spent stopped, saturating
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      stopCnt_ff <= 5'h1f;
    else if (opSh_ff != 2'h0)
      stopCnt_ff <= 5'h00;
    else if (stopCnt_ff != 5'h1f)
      stopCnt_ff <= stopCnt_ff + 5'h01;
  end
  a_ready_high: assert property (hreadyout)
    else $error("hreadyout low");
  a_resp_okay: assert property (!hresp)
    else $error("error response seen");
  a_irqa_pulse: assert property (event_irq_a |=> !event_irq_a)
    else $error("irq a longer than one cycle");
  a_irqb_pulse: assert property ($rose(event_irq_b) |=> $fell(event_irq_b))
    else $error("irq b longer than one cycle");
  a_stop_quiet: assert property (stopCnt_ff >= 5'h14 |-> !(event_irq_a || event_irq_b))
    else $error("event while stopped");
  a_count_stopped: assert property (rdPh_ff && adrPh_ff == tcx_pkg::OFS_COUNT
    && stopCnt_ff >= 5'h14 |-> hrdata == 32'h0) else $error("count moved while stopped");
  a_unmapped_zero: assert property (rdPh_ff && adrPh_ff > tcx_pkg::OFS_STATUS |-> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_upper_zero: assert property (rdPh_ff |-> hrdata[31:16] == 16'h0)
    else $error("upper read bits set");
endmodule

//--- tb/tcx_pin_source.sv
// Purpose: External signal source on the two input pins.
// Assumes: Levels change just after a rising clock edge.
// Notes: Pins are always driven, idle low.
`timescale 1ns/100ps
module tcx_pin_source
(
  // Clock
  input wire logic clk,
  // Pins
  output logic pinA,
  output logic pinB
);
  // Idle level at start
  initial
  begin
    pinA = 1'b0;
    pinB = 1'b0;
  end
  // Set one pin and hold it n cycles
  task automatic drive(input int sel, input logic lvl, input int n);
    if (sel == 0)
      pinA <= lvl;
    else
      pinB <= lvl;
    repeat (n) @(posedge clk);
  endtask
  // High then low pulse
  task automatic pulse(input int sel, input int hi, input int lo);
    drive(sel, 1'b1, hi);
    drive(sel, 1'b0, lo);
  endtask
endmodule

//--- tb/tcx_timer_tb.sv
// Purpose: Self-checking bench for the timer block.
// Assumes: Zero wait bus slave; count clock at clk/2, except clk/4 in the clear-on-edge test and input a as count clock.
// Notes: Expected values come from the small model below.
`timescale 1ns/100ps
module tcx_timer_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic extA;
  logic extB;
  logic evA;
  logic evB;
  logic shot;
  logic [31:0] rd;
  int err_count = 0;
  int n_compared = 0;
  int seed = 32'h1adb;
  // Model state
  int nA = 0;
  int nB = 0;
  int mdlA;
  int mdlB;
  int c0;
  int w;
  int seen;
  always #20 clk = ~clk;
  tcx_timer DUT (.clk(clk), .rst_n(rst_n), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .ext_input_a(extA), .ext_input_b(extB),
    .event_irq_a(evA), .event_irq_b(evB), .oneShotOut(shot));
  tcx_pin_source src (.clk(clk), .pinA(extA), .pinB(extB));
  // Count event pulses
  always @(posedge clk)
  begin
    if (evA === 1'b1)
      nA <= nA + 1;
    if (evB === 1'b1)
      nB <= nB + 1;
  end
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      err_count++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Bus cycles: address phase, then data phase
  task automatic busWr(input logic [7:0] a, input logic [31:0] d);
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= 1'b1;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
  endtask
  task automatic busRd(input logic [7:0] a, output logic [31:0] d);
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= 1'b0;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    do @(posedge clk); while (hreadyout !== 1'b1);
    d = hrdata;
  endtask
  task automatic rdChk(input string nm, input logic [7:0] a, input logic [31:0] e);
    busRd(a, rd);
    chk(nm, e, rd);
  endtask
  task automatic waitc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Note whether the one-shot output goes high
  task automatic watch(input int n, output int s);
    s = 0;
    repeat (n)
    begin
      @(posedge clk);
      if (shot === 1'b1)
        s = 1;
    end
  endtask
  // Watchdog
  initial
  begin
    waitc(6000);
    err_count++;
    $display("unexpected timeout");
    test_done;
  end
  // Main sequence
  initial
  begin
    waitc(20);
    rst_n <= 1'b1;
    @(posedge clk);
    // Reset values, access, unmapped place
    for (int i = 0; i < 7; i++)
      rdChk("reset value", 8'(4 * i), 32'h0);
    // Kept high so a compare match on regA cannot fire during the short free runs
    mdlA = ($random(seed) & 32'h7fff) | 32'h8000;
    busWr(tcx_pkg::OFS_REGA, mdlA);
    rdChk("regA", tcx_pkg::OFS_REGA, mdlA);
    busWr(8'h1c, 32'hffffffff);
    rdChk("unmapped", 8'h1c, 32'h0);
    // Pin a ignored while stopped
    busWr(tcx_pkg::OFS_PRESCALER, 32'h10);
    busWr(tcx_pkg::OFS_CAPCTL, 32'h4);
    src.pulse(0, 8, 8);
    chk("irqB stopped", 0, nB);
    rdChk("regB stopped", tcx_pkg::OFS_REGB, 32'h0);
    rdChk("count stopped", tcx_pkg::OFS_COUNT, 32'h0);
    // Free run; a glitch, then a real capture pulse
    busWr(tcx_pkg::OFS_MODE, 32'h8);
    waitc(10);
    src.pulse(0, 1, 10);
    chk("irqB glitch", 0, nB);
    busRd(tcx_pkg::OFS_COUNT, rd);
    c0 = rd;
    chk("count running", 1, c0 > 0);
    w = 5 + ($unsigned($random(seed)) % 8);
    src.pulse(0, w, 12);
    chk("irqB capture", 1, nB);
    busRd(tcx_pkg::OFS_REGB, rd);
    mdlB = rd;
    busRd(tcx_pkg::OFS_COUNT, rd);
    chk("regB window", 1, mdlB > c0 && mdlB < rd);
    // Count reads leave regB alone
    repeat (3) busRd(tcx_pkg::OFS_COUNT, rd);
    rdChk("regB after reads", tcx_pkg::OFS_REGB, mdlB);
    // Compare mode registers ignore triggers
    busWr(tcx_pkg::OFS_CAPCTL, 32'h0);
    busWr(tcx_pkg::OFS_REGA, 32'hffff);
    src.pulse(1, 8, 8);
    src.pulse(0, 8, 8);
    rdChk("regA compare", tcx_pkg::OFS_REGA, 32'hffff);
    rdChk("regB compare", tcx_pkg::OFS_REGB, mdlB);
    chk("irqB compare", 1, nB);
    // Input a as count clock: counts edges, no capture
    busWr(tcx_pkg::OFS_MODE, 32'h0);
    busWr(tcx_pkg::OFS_REGA, 32'h1234);
    busWr(tcx_pkg::OFS_CAPCTL, 32'h3);
    busWr(tcx_pkg::OFS_PRESCALER, 32'h13);
    busWr(tcx_pkg::OFS_MODE, 32'h8);
    repeat (5) src.pulse(0, 2, 2);
    waitc(4);
    rdChk("edge count", tcx_pkg::OFS_COUNT, 32'h5);
    rdChk("regA no capture", tcx_pkg::OFS_REGA, 32'h1234);
    chk("irqA no capture", 0, nA);
    // One-shot output per mode
    busWr(tcx_pkg::OFS_MODE, 32'h0);
    busWr(tcx_pkg::OFS_PRESCALER, 32'h0);
    busWr(tcx_pkg::OFS_CAPCTL, 32'h0);
    busWr(tcx_pkg::OFS_REGB, 32'h2);
    busWr(tcx_pkg::OFS_REGA, 32'ha);
    busWr(tcx_pkg::OFS_MODE, 32'hd);
    watch(80, seen);
    chk("shot clear on match", 0, seen);
    busWr(tcx_pkg::OFS_MODE, 32'h0);
    busWr(tcx_pkg::OFS_MODE, 32'h9);
    watch(80, seen);
    chk("shot free run", 1, seen);
    // Clear-on-input-edge mode at the divide-by-four count clock
    busWr(tcx_pkg::OFS_MODE, 32'h0);
    busWr(tcx_pkg::OFS_PRESCALER, 32'h1);
    busWr(tcx_pkg::OFS_MODE, 32'h5);
    watch(80, seen);
    chk("shot clear on edge", 1, seen);
    // Pin b high through reset, first start, then restart
    busWr(tcx_pkg::OFS_MODE, 32'h0);
    src.drive(1, 1'b1, 2);
    rst_n <= 1'b0;
    waitc(20);
    rst_n <= 1'b1;
    @(posedge clk);
    busWr(tcx_pkg::OFS_PRESCALER, 32'h40);
    busWr(tcx_pkg::OFS_CAPCTL, 32'h1);
    mdlA = nA + 1;
    busWr(tcx_pkg::OFS_MODE, 32'h8);
    waitc(20);
    chk("irqA first start", mdlA, nA);
    busWr(tcx_pkg::OFS_MODE, 32'h0);
    waitc(30);
    busWr(tcx_pkg::OFS_MODE, 32'h8);
    waitc(30);
    chk("irqA restart", mdlA, nA);
    test_done;
  end
endmodule
bind tcx_timer tcx_timer_checker chk_i (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .event_irq_a(event_irq_a), .event_irq_b(event_irq_b));
